// ==== core/osfl_pkg.sv ====
package osfl_pkg;
    localparam int NUM_OUT = 8;
    localparam int CLK_PERIOD_NS = 10;
    // Turn-on delay window, least figure, rounded up
    localparam int WIN_MIN_US = 70;
    localparam int WIN_CYCLES = (WIN_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Current-limit entry between these two figures
    localparam int LIMIT_MIN_NS = 5000;
    localparam int LIMIT_MAX_NS = 10000;
    localparam int LIMIT_CYCLES = (LIMIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Late short shutdown bound, rounded down
    localparam int TRIP_MAX_NS = 20000;
    localparam int TRIP_CYCLES = TRIP_MAX_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam int LIM_W = 10;
    localparam logic [7:0] WORD_ALL_OFF = 8'hff;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;
    localparam logic [3:0] BITS_ZERO = 4'h0;

    typedef enum logic [1:0] {
        CH_OFF  = 2'b00,
        CH_WIN  = 2'b01,
        CH_ON   = 2'b10,
        CH_TRIP = 2'b11
    } osfl_chan_state_type;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic si;
        logic short_shutdown_select;
        logic load_over_voltage;
        logic logic_under_voltage;
        logic [7:0] drain_fault_threshold;
        logic [7:0] over_temp;
    } osfl_pins_type;
endpackage

// ==== core/osfl_channel.sv ====
`timescale 1ns/1ps
module osfl_channel #(
    parameter int DELAY_CYCLES = osfl_pkg::WIN_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command
    input wire logic load,
    input wire logic cmd_on,
    input wire logic sel,
    // Sensing
    input wire logic drain_high,
    input wire logic over_temp,
    input wire logic global_off,
    // Results
    output logic gate,
    output logic limit
);
    osfl_pkg::osfl_chan_state_type st_ff, nxt_st;
    logic [osfl_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [osfl_pkg::LIM_W-1:0] lim_ff, nxt_lim;
    logic therm_ff, nxt_therm;
    logic gate_ff, nxt_gate;
    logic limit_ff, nxt_limit;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_therm = therm_ff;
        nxt_lim = lim_ff;
        nxt_limit = 1'b0;
        if (load) begin
            if (!over_temp) begin
                nxt_therm = 1'b0;
            end
            if (cmd_on) begin
                nxt_st = osfl_pkg::CH_WIN;
                nxt_cnt = '0;
            end else begin
                nxt_st = osfl_pkg::CH_OFF;
            end
        end else begin
            case (st_ff)
                osfl_pkg::CH_WIN: begin
                    nxt_cnt = cnt_ff + 16'h0001;
                    if (cnt_ff == osfl_pkg::CNT_W'(DELAY_CYCLES - 1)) begin
                        nxt_st = (drain_high && !sel) ? osfl_pkg::CH_TRIP : osfl_pkg::CH_ON;
                    end
                end
                osfl_pkg::CH_ON: begin
                    if (gate_ff && drain_high && !sel) begin
                        nxt_st = osfl_pkg::CH_TRIP;
                    end
                end
                osfl_pkg::CH_TRIP: nxt_st = osfl_pkg::CH_TRIP;
                osfl_pkg::CH_OFF: nxt_st = osfl_pkg::CH_OFF;
                default: nxt_st = osfl_pkg::CH_OFF;
            endcase
        end
        // Thermal latch, set wins over the clear
        if (over_temp) begin
            nxt_therm = 1'b1;
        end
        // Current limit after the least entry time while the short stays
        if (sel && gate_ff && drain_high) begin
            if (lim_ff == osfl_pkg::LIM_W'(osfl_pkg::LIMIT_CYCLES)) begin
                nxt_limit = 1'b1;
            end else begin
                nxt_lim = lim_ff + 10'h001;
            end
        end else begin
            nxt_lim = '0;
        end
        nxt_gate = (nxt_st == osfl_pkg::CH_WIN || nxt_st == osfl_pkg::CH_ON)
            && !nxt_therm && !global_off;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= osfl_pkg::CH_OFF;
            cnt_ff <= '0;
            lim_ff <= '0;
            therm_ff <= 1'b0;
            gate_ff <= 1'b0;
            limit_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            lim_ff <= nxt_lim;
            therm_ff <= nxt_therm;
            gate_ff <= nxt_gate;
            limit_ff <= nxt_limit;
        end
    end

    assign gate = gate_ff;
    assign limit = limit_ff;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    AST_WIN_START: assert property (load && cmd_on |=> st_ff == osfl_pkg::CH_WIN)
        else $error("window not started on load");
    AST_NO_EARLY_TRIP: assert property (st_ff == osfl_pkg::CH_WIN && !load &&
        cnt_ff != osfl_pkg::CNT_W'(DELAY_CYCLES - 1) |=> st_ff != osfl_pkg::CH_TRIP)
        else $error("trip inside delay window");
    AST_LATE_TRIP: assert property (st_ff == osfl_pkg::CH_ON && gate_ff && drain_high
        && !sel && !load |=> !gate_ff ##0 st_ff == osfl_pkg::CH_TRIP)
        else $error("late short not shut down");
    AST_SEL_NO_TRIP: assert property (sel && !load && st_ff != osfl_pkg::CH_TRIP
        |=> st_ff != osfl_pkg::CH_TRIP)
        else $error("trip while limit mode selected");
    AST_LIMIT_NOT_EARLY: assert property (sel && gate_ff && drain_high
        && lim_ff == 10'h000 |=> !limit_ff [*2])
        else $error("current limit entered too early");
    AST_TRIP_STAYS_OFF: assert property (st_ff == osfl_pkg::CH_TRIP && !load |=> !gate_ff)
        else $error("tripped output came back");
    AST_THERM_OFF: assert property (over_temp |=> !gate_ff)
        else $error("output on during over-temperature");
    AST_AUTO_RESUME: assert property (sel && st_ff == osfl_pkg::CH_ON && !drain_high
        && !therm_ff && !over_temp && !global_off && !load |=> gate_ff)
        else $error("output did not resume");
endmodule

// ==== core/osfl_top.sv ====
`timescale 1ns/1ps
// Function
// - Chip select rise with output on starts that output and its delay window.
// - Select low: short before or in window trips only at window end.
// - Select low: short after window trips the output within 20 us.
// - Select high: never trip on over-current; limit within 5 to 10 us.
// - Each output has its own shutdown logic; thermal and over-voltage ignore select.
// - Select high: output resumes when short goes, unless thermally shut down.
// - Select low: tripped output stays off until the next write cycle.
// - Select low, persistent short: each on command gives one window then trips again.
// - Logic supply under-voltage turns all outputs off and sets status all off.
// - Load supply under-voltage neither shuts down nor resets anything.
// - Status bit equal to previous command bit means no fault.
// - Command bit high programs output off, low programs it on.
// - Output commanded off with open load returns status low.
// - Output commanded on with over-current returns status high.
// - Over-temperature disables only that output until the first write cycle after it clears.
// - Load supply over-voltage turns all outputs off and latches them off.
// - Device samples data on clock fall and changes status on clock rise.
// - Chip select rise applies the word; chip select fall loads status.
// - First word after over-voltage shifts out all ones.
module osfl_top #(
    parameter int DELAY_CYCLES = osfl_pkg::WIN_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    // Mode and supply monitors
    input wire logic short_shutdown_select,
    input wire logic load_over_voltage,
    input wire logic logic_under_voltage,
    // Per-output sensing
    input wire logic [7:0] drain_fault_threshold,
    input wire logic [7:0] over_temp,
    // Output switches
    output logic [7:0] out_on,
    output logic [7:0] out_limit
);
    osfl_pkg::osfl_pins_type pins_w;
    osfl_pkg::osfl_pins_type s1_ff, s2_ff;
    logic sclk_d_ff, cs_n_d_ff;
    logic [7:0] shift_ff, nxt_shift;
    logic [3:0] bits_ff, nxt_bits;
    logic so_ff, nxt_so;
    logic so_oe_n_ff, nxt_so_oe_n;
    logic [7:0] cmd_ff, nxt_cmd;
    logic ov_latch_ff, nxt_ov_latch;
    logic ov_report_ff, nxt_ov_report;
    logic load_ff, nxt_load;
    logic rst_all;
    logic cs_fall, cs_rise, sclk_fall, sclk_rise;
    logic global_off;
    logic [7:0] status_w;
    logic [7:0] gate_w;
    logic [7:0] limit_w;

    assign pins_w = '{
        sclk: sclk,
        cs_n: cs_n,
        si: si,
        short_shutdown_select: short_shutdown_select,
        load_over_voltage: load_over_voltage,
        logic_under_voltage: logic_under_voltage,
        drain_fault_threshold: drain_fault_threshold,
        over_temp: over_temp
    };

    // Two-stage synchroniser for every pin input
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_ff <= '{sclk: 1'b0, cs_n: 1'b1, default: '0};
            s2_ff <= '{sclk: 1'b0, cs_n: 1'b1, default: '0};
            sclk_d_ff <= 1'b0;
            cs_n_d_ff <= 1'b1;
        end else begin
            s1_ff <= pins_w;
            s2_ff <= s1_ff;
            sclk_d_ff <= s2_ff.sclk;
            cs_n_d_ff <= s2_ff.cs_n;
        end
    end

    assign rst_all = reset || s2_ff.logic_under_voltage;
    assign cs_fall = cs_n_d_ff && !s2_ff.cs_n;
    assign cs_rise = !cs_n_d_ff && s2_ff.cs_n;
    assign sclk_fall = sclk_d_ff && !s2_ff.sclk && !s2_ff.cs_n;
    assign sclk_rise = !sclk_d_ff && s2_ff.sclk && !s2_ff.cs_n;
    // Load supply sag has no input: outputs keep following the command word
    assign global_off = ov_latch_ff || s2_ff.load_over_voltage;

    // Serial word, command latch and over-voltage bookkeeping
    always_comb begin
        nxt_shift = shift_ff;
        nxt_bits = bits_ff;
        nxt_so = so_ff;
        nxt_so_oe_n = so_oe_n_ff;
        nxt_cmd = cmd_ff;
        nxt_ov_latch = ov_latch_ff;
        nxt_ov_report = ov_report_ff;
        nxt_load = 1'b0;
        if (cs_fall) begin
            nxt_shift = ov_report_ff ? osfl_pkg::WORD_ALL_OFF : status_w;
            nxt_bits = osfl_pkg::BITS_ZERO;
            nxt_so = nxt_shift[7];
            nxt_so_oe_n = 1'b0;
        end else if (sclk_fall && bits_ff != osfl_pkg::BITS_PER_WORD) begin
            nxt_shift = {shift_ff[6:0], s2_ff.si};
            nxt_bits = bits_ff + 4'h1;
        end else if (sclk_rise) begin
            nxt_so = shift_ff[7];
        end else if (cs_rise) begin
            nxt_so_oe_n = 1'b1;
            if (bits_ff == osfl_pkg::BITS_PER_WORD) begin
                nxt_cmd = shift_ff;
                nxt_load = 1'b1;
                nxt_ov_report = 1'b0;
                if (!s2_ff.load_over_voltage) begin
                    nxt_ov_latch = 1'b0;
                end
            end
        end
        if (s2_ff.load_over_voltage) begin
            nxt_ov_latch = 1'b1;
            nxt_ov_report = 1'b1;
            nxt_cmd = osfl_pkg::WORD_ALL_OFF;
            nxt_load = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            shift_ff <= osfl_pkg::WORD_ALL_OFF;
            bits_ff <= osfl_pkg::BITS_ZERO;
            so_ff <= 1'b1;
            so_oe_n_ff <= 1'b1;
            cmd_ff <= osfl_pkg::WORD_ALL_OFF;
            ov_latch_ff <= 1'b0;
            ov_report_ff <= 1'b0;
            load_ff <= 1'b0;
        end else begin
            shift_ff <= nxt_shift;
            bits_ff <= nxt_bits;
            so_ff <= nxt_so;
            so_oe_n_ff <= nxt_so_oe_n;
            cmd_ff <= nxt_cmd;
            ov_latch_ff <= nxt_ov_latch;
            ov_report_ff <= nxt_ov_report;
            load_ff <= nxt_load;
        end
    end

    // One independent protection channel per output
    genvar gi;
    generate
        for (gi = 0; gi < osfl_pkg::NUM_OUT; gi++) begin : g_chan
            osfl_channel #(
                .DELAY_CYCLES(DELAY_CYCLES)
            ) u_chan (
                .clk(clk),
                .reset(rst_all),
                .load(load_ff),
                .cmd_on(!cmd_ff[gi]),
                .sel(s2_ff.short_shutdown_select),
                .drain_high(s2_ff.drain_fault_threshold[gi]),
                .over_temp(s2_ff.over_temp[gi]),
                .global_off(global_off),
                .gate(gate_w[gi]),
                .limit(limit_w[gi])
            );
            // Drain above threshold: short when on, healthy when off
            assign status_w[gi] = !cmd_ff[gi]
                ? (s2_ff.drain_fault_threshold[gi] || !gate_w[gi])
                : s2_ff.drain_fault_threshold[gi];
        end
    endgenerate

    assign so = so_ff;
    assign so_oe_n = so_oe_n_ff;
    assign out_on = gate_w;
    assign out_limit = limit_w;

    default clocking @(posedge clk); endclocking
    default disable iff (rst_all);

    AST_CAPTURE: assert property (cs_fall && !ov_report_ff
        |=> shift_ff == $past(status_w) && !so_oe_n_ff)
        else $error("status not loaded at chip select fall");
    AST_OV_WORD: assert property (cs_fall && ov_report_ff |=> shift_ff == 8'hff)
        else $error("over-voltage word not all ones");
    AST_OV_OFF: assert property (s2_ff.load_over_voltage |=> out_on == 8'h00 ##1 ov_latch_ff)
        else $error("outputs not off on over-voltage");
    AST_SHORT_WORD: assert property (cs_rise && bits_ff != 4'h8
        && !s2_ff.load_over_voltage |=> cmd_ff == $past(cmd_ff) && !load_ff)
        else $error("short word applied");
    AST_APPLY: assert property (cs_rise && bits_ff == 4'h8 && !s2_ff.load_over_voltage
        |=> cmd_ff == $past(shift_ff) && load_ff)
        else $error("full word not applied");
    AST_SHIFT_IN: assert property (sclk_fall && bits_ff == 4'h0 && !cs_fall
        |=> shift_ff[0] == $past(s2_ff.si) && bits_ff == 4'h1)
        else $error("data not sampled on clock fall");

    AST_UV_RESET: assert property (@(posedge clk) disable iff (reset)
        s2_ff.logic_under_voltage |=> shift_ff == 8'hff && cmd_ff == 8'hff && out_on == 8'h00)
        else $error("under-voltage did not reset");
endmodule

// ==== tb/osfl_host.sv ====
`timescale 1ns/1ps
module osfl_host (
    // Clock
    input wire logic clk,
    // Serial link
    input wire logic so,
    output logic sclk,
    output logic cs_n,
    output logic si
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Frame of nbits; status taken as the clock falls
    task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] st);
        st = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        wait_clk(8);
        for (int i = 0; i < nbits; i++) begin
            sclk <= 1'b1;
            si <= cmd[7 - i];
            wait_clk(8);
            sclk <= 1'b0;
            st[7 - i] = so;
            wait_clk(8);
        end
        cs_n <= 1'b1;
        // Released data line shows the inverse
        si <= ~si;
        wait_clk(8);
    endtask
endmodule

// ==== tb/osfl_top_tb.sv ====
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end
module osfl_top_tb;
    localparam int DLY = 20;
    logic clk, reset, sel, ov, uv, so, so_oe_n, sclk, cs_n, si;
    logic [7:0] drain, temp, st, out_on, out_limit;
    int miscompares = 0;
    int checks_done = 0;

    osfl_top #(.DELAY_CYCLES(DLY)) i_osfl_top (
        .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
        .so_oe_n(so_oe_n), .short_shutdown_select(sel), .load_over_voltage(ov),
        .logic_under_voltage(uv), .drain_fault_threshold(drain), .over_temp(temp),
        .out_on(out_on), .out_limit(out_limit));
    osfl_host i_osfl_host (.clk(clk), .so(so), .sclk(sclk), .cs_n(cs_n), .si(si));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic xfer(input logic [7:0] cmd);
        i_osfl_host.xfer(cmd, 8, st);
    endtask

    task automatic t_cmd();
        drain <= 8'h5a;
        xfer(8'h5a);
        `CHK("out_on", 8'ha5, out_on)
        xfer(8'h5a);
        `CHK("status", 8'h5a, st)
        drain <= 8'hfe;
        xfer(8'hff);
        xfer(8'hff);
        `CHK("status", 8'hfe, st)
        `CHK("out_on", 8'h00, out_on)
        $display("test cmd done");
    endtask

    task automatic t_late();
        xfer(8'hfe);
        step(DLY + 10);
        `CHK("out_on", 8'h01, out_on)
        drain <= 8'hff;
        step(10);
        `CHK("out_on", 8'h00, out_on)
        drain <= 8'hfe;
        step(10);
        `CHK("out_on", 8'h00, out_on)
        xfer(8'hfe);
        `CHK("status", 8'hff, st)
        `CHK("out_on", 8'h01, out_on)
        $display("test late short done");
    endtask

    task automatic t_early();
        drain <= 8'hff;
        for (int r = 0; r < 2; r++) begin
            xfer(8'hfe);
            step(8);
            `CHK("out_on", 8'h01, out_on)
            step(DLY + 6);
            `CHK("out_on", 8'h00, out_on)
        end
        $display("test early short done");
    endtask

    task automatic t_limit();
        sel <= 1'b1;
        drain <= 8'hfe;
        xfer(8'hfe);
        step(DLY + 10);
        drain <= 8'hff;
        step(400);
        `CHK("out_limit", 8'h00, out_limit)
        step(600);
        `CHK("out_limit", 8'h01, out_limit)
        `CHK("out_on", 8'h01, out_on)
        xfer(8'hfe);
        `CHK("status", 8'hff, st)
        drain <= 8'hfe;
        step(10);
        `CHK("out_limit", 8'h00, out_limit)
        `CHK("out_on", 8'h01, out_on)
        $display("test limit done");
    endtask

    task automatic t_temp_ov();
        for (int s = 0; s < 2; s++) begin
            sel <= s[0];
            drain <= 8'hfc;
            xfer(8'hfc);
            step(DLY + 10);
            temp <= 8'h02;
            step(6);
            `CHK("out_on", 8'h01, out_on)
            temp <= 8'h00;
            step(6);
            xfer(8'hfc);
            `CHK("out_on", 8'h03, out_on)
            ov <= 1'b1;
            step(6);
            `CHK("out_on", 8'h00, out_on)
            ov <= 1'b0;
            step(10);
            `CHK("out_on", 8'h00, out_on)
            xfer(8'h00);
            `CHK("status", 8'hff, st)
            `CHK("out_on", 8'hff, out_on)
        end
        i_osfl_host.xfer(8'hff, 7, st);
        `CHK("out_on", 8'hff, out_on)
        $display("test temp and over-voltage done");
    endtask

    task automatic t_uv();
        uv <= 1'b1;
        step(6);
        `CHK("out_on", 8'h00, out_on)
        uv <= 1'b0;
        drain <= 8'hff;
        step(6);
        `CHK("so", 1'b1, so)
        xfer(8'hff);
        `CHK("status", 8'hff, st)
        $display("test under-voltage done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        sel = 1'b0;
        ov = 1'b0;
        uv = 1'b0;
        drain = 8'hff;
        temp = 8'h00;
        step(8);
        reset <= 1'b0;
        // Select pin set again after the reset is released
        sel <= 1'b0;
        step(3);
        `CHK("out_on", 8'h00, out_on)
        `CHK("so_oe_n", 1'b1, so_oe_n)
        t_cmd();
        t_late();
        t_early();
        t_limit();
        t_temp_ov();
        t_uv();
        complete_run();
    end

    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
endmodule
